//--- rtl/ssr_status_regs.sv
// Read-only status register group of a power sequencer.
// Assumes the sequencing, watchdog and self-test engines drive event
// and level inputs on clk_in; pin levels arrive asynchronously.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Functional notes
// - Bit5 low while interrupt pin pulled
// - Bit4 low while reset pin pulled
// - Bit3 mirrors sleep input
// - Bit2 mirrors run-request input
// - Bits1:0 give power state code
// - Drive state per enable pin
// - Readback level per enable pin
// - Watchdog bit3 shows open window
// - Early service flag, clear on read
// - Window expired flag, clear on read
// - Self-test done bit
// - Single-error corrected bit
// - Bits3:0 self-test failure results
// - Cause record retained, overwritten per event
// - Emergency shutdown logging optional
// - Bit7 external reset input cause
// - Bit6 watchdog reset cause
// - Bit4 emergency off input cause
// - Bit3 run input low cause
// - Bit2 watchdog shutdown cause
// - Bits1:0 forced code or watchdog mode
module ssr_status_regs (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic rd_en_in,
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	// Internal drive state of output pins
	input wire logic irq_drive_low_in,
	input wire logic rst_drive_low_in,
	input wire logic [11:0] enable_drive_state_in,
	input wire logic [1:0] power_state_code_in,
	// Asynchronous pin levels
	input wire logic sleep_pin_in,
	input wire logic run_request_input_in,
	input wire logic [11:0] enable_pin_level_in,
	// Watchdog engine
	input wire logic wd_window_open_in,
	input wire logic wd_early_service_in,
	input wire logic wd_expired_in,
	// Self-test engine
	input wire logic self_test_done_in,
	input wire logic single_error_corrected_in,
	input wire logic [3:0] self_test_fail_in,
	// Reset or shutdown event with its cause
	input wire logic cause_event_in,
	input wire logic external_reset_input_in,
	input wire logic watchdog_reset_cause_in,
	input wire logic emergency_off_input_in,
	input wire logic run_low_cause_in,
	input wire logic watchdog_shutdown_cause_in,
	input wire logic [1:0] forced_off_code_in,
	input wire logic [1:0] watchdog_off_mode_in
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers: a change counts once stages two and three agree
	localparam int NSYNC = 2 + ssr_pkg::NUM_EN;
	logic [NSYNC-1:0] sync1_ff, sync2_ff, sync3_ff, pin_lvl_ff;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= {enable_pin_level_in, sleep_pin_in,
				run_request_input_in};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pin_lvl_ff <= '0;
		end else begin
			for (int i = 0; i < NSYNC; i++) begin
				if (sync2_ff[i] == sync3_ff[i])
					pin_lvl_ff[i] <= sync3_ff[i];
			end
		end
	end

////////////////////////////////////////////////////////////////////////
// Live status snapshot
	logic [7:0] ctl_ff, drv_hi_ff, drv_lo_ff, rdb_hi_ff, rdb_lo_ff;
	logic [7:0] test_ff;
	logic [7:0] nxt_ctl;

	always_comb begin
		nxt_ctl = ssr_pkg::RST_VAL;
		nxt_ctl[ssr_pkg::CTL_IRQ_BIT] = ~irq_drive_low_in;
		nxt_ctl[ssr_pkg::CTL_RST_BIT] = ~rst_drive_low_in;
		nxt_ctl[ssr_pkg::CTL_SLP_BIT] = pin_lvl_ff[1];
		nxt_ctl[ssr_pkg::CTL_RUN_BIT] = pin_lvl_ff[0];
		nxt_ctl[1:0] = (power_state_code_in == 2'h2) ? ssr_pkg::PS_OFF
			: power_state_code_in;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctl_ff <= ssr_pkg::RST_VAL;
			drv_hi_ff <= ssr_pkg::RST_VAL;
			drv_lo_ff <= ssr_pkg::RST_VAL;
			rdb_hi_ff <= ssr_pkg::RST_VAL;
			rdb_lo_ff <= ssr_pkg::RST_VAL;
		end else begin
			ctl_ff <= nxt_ctl;
			drv_hi_ff <= {4'h0, enable_drive_state_in[11:8]};
			drv_lo_ff <= enable_drive_state_in[7:0];
			rdb_hi_ff <= {4'h0, pin_lvl_ff[13:10]};
			rdb_lo_ff <= pin_lvl_ff[9:2];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			test_ff <= ssr_pkg::RST_VAL;
		end else begin
			test_ff <= ssr_pkg::RST_VAL;
			test_ff[ssr_pkg::ST_DONE_BIT] <= self_test_done_in;
			test_ff[ssr_pkg::ST_SEC_BIT] <= single_error_corrected_in;
			test_ff[3:0] <= self_test_fail_in;
		end
	end

////////////////////////////////////////////////////////////////////////
// Watchdog flags; a set in the read cycle survives the clear
	logic open_ff, early_ff, exp_ff;
	logic wd_read;

	assign wd_read = rd_en_in && (addr_in == ssr_pkg::OFS_WDT);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			open_ff <= 1'b0;
			early_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else begin
			open_ff <= wd_window_open_in;
			if (wd_early_service_in)
				early_ff <= 1'b1;
			else if (wd_read)
				early_ff <= 1'b0;
			if (wd_expired_in)
				exp_ff <= 1'b1;
			else if (wd_read)
				exp_ff <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////
// Last cause record, rewritten whole on each event only
	logic [7:0] last_ff;
	logic [7:0] nxt_last;

	always_comb begin
		nxt_last = ssr_pkg::RST_VAL;
		nxt_last[ssr_pkg::LR_EXT_BIT] = external_reset_input_in;
		nxt_last[ssr_pkg::LR_WDR_BIT] = watchdog_reset_cause_in;
		nxt_last[ssr_pkg::LR_EMO_BIT] = emergency_off_input_in;
		nxt_last[ssr_pkg::LR_RUN_BIT] = run_low_cause_in;
		nxt_last[ssr_pkg::LR_WDS_BIT] = watchdog_shutdown_cause_in;
		nxt_last[1:0] = watchdog_shutdown_cause_in ?
			watchdog_off_mode_in : forced_off_code_in;
	end

	// emergency logged like any cause, allowed
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			last_ff <= ssr_pkg::RST_VAL;
		else if (cause_event_in)
			last_ff <= nxt_last;
	end

////////////////////////////////////////////////////////////////////////
// Read mux; writes are decoded nowhere so they have no effect
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	always_comb begin
		case (addr_in)
			ssr_pkg::OFS_CTL_PIN: nxt_rdata = ctl_ff;
			ssr_pkg::OFS_DRV_HI: nxt_rdata = drv_hi_ff;
			ssr_pkg::OFS_DRV_LO: nxt_rdata = drv_lo_ff;
			ssr_pkg::OFS_RDB_HI: nxt_rdata = rdb_hi_ff;
			ssr_pkg::OFS_RDB_LO: nxt_rdata = rdb_lo_ff;
			ssr_pkg::OFS_WDT: nxt_rdata = {4'h0, open_ff, 1'b0,
				early_ff, exp_ff};
			ssr_pkg::OFS_TEST: nxt_rdata = test_ff;
			ssr_pkg::OFS_LAST: nxt_rdata = last_ff;
			default: nxt_rdata = ssr_pkg::RST_VAL;
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			rdata_ff <= ssr_pkg::RST_VAL;
		else if (rd_en_in)
			rdata_ff <= nxt_rdata;
	end

	assign rdata_out = rdata_ff;

////////////////////////////////////////////////////////////////////////
// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_irq_bit_level: assert property (
		##1 ctl_ff[5] == !$past(irq_drive_low_in))
		else $error("irq state bit wrong");
	a_rst_bit_level: assert property (
		##1 ctl_ff[4] == !$past(rst_drive_low_in))
		else $error("reset state bit wrong");
	a_sleep_mirror: assert property (
		$stable(sleep_pin_in)[*6] |-> ctl_ff[3] == sleep_pin_in)
		else $error("sleep mirror wrong");
	a_run_mirror: assert property (
		$stable(run_request_input_in)[*6] |->
			ctl_ff[2] == run_request_input_in)
		else $error("run mirror wrong");
	a_state_valid: assert property (
		ctl_ff[1:0] != 2'h2)
		else $error("invalid power state code");
	a_drive_split: assert property (
		##1 {drv_hi_ff[3:0], drv_lo_ff} == $past(enable_drive_state_in))
		else $error("drive state wrong");
	a_early_clear: assert property (
		wd_read && !wd_early_service_in |=> !early_ff)
		else $error("early flag not cleared on read");
	a_exp_hold: assert property (
		wd_expired_in |=> exp_ff[*1] ##1 (exp_ff || $past(wd_read)))
		else $error("expired flag lost");
	a_cause_keep: assert property (
		!cause_event_in |=> $stable(last_ff))
		else $error("cause record changed without event");
	a_wds_mode: assert property (
		cause_event_in && watchdog_shutdown_cause_in |=>
			last_ff[1:0] == $past(watchdog_off_mode_in))
		else $error("watchdog mode not recorded");
	a_rsvd_zero: assert property (
		ctl_ff[7:6] == 2'h0 && test_ff[7] == 1'b0 && last_ff[5] == 1'b0)
		else $error("reserved bit set");
	a_test_done: assert property (
		##1 test_ff[6] == $past(self_test_done_in))
		else $error("self-test done wrong");

	// Power state and enable readback
	a_state_pass: assert property (
		power_state_code_in != 2'h2 |=>
			ctl_ff[1:0] == $past(power_state_code_in))
		else $error("power state code not passed");
	a_state_fold: assert property (
		power_state_code_in == 2'h2 |=> ctl_ff[1:0] == 2'h0)
		else $error("invalid power state not folded");
	a_readback_sync: assert property (
		$stable(enable_pin_level_in)[*6] |->
			{rdb_hi_ff[3:0], rdb_lo_ff} == enable_pin_level_in)
		else $error("enable readback wrong");

	// Watchdog flags: a set in the read cycle must win
	a_open_level: assert property (
		##1 open_ff == $past(wd_window_open_in))
		else $error("window open bit wrong");
	a_early_set: assert property (
		wd_early_service_in |=> early_ff)
		else $error("early flag not set");
	a_early_hold: assert property (
		early_ff && !wd_read |=> early_ff)
		else $error("early flag lost without read");
	a_early_rise: assert property (
		$rose(early_ff) |-> $past(wd_early_service_in))
		else $error("early flag set without event");
	a_exp_set: assert property (
		wd_expired_in |=> exp_ff)
		else $error("expired flag not set");
	a_exp_clear: assert property (
		wd_read && !wd_expired_in |=> !exp_ff)
		else $error("expired flag not cleared on read");
	a_exp_rise: assert property (
		$rose(exp_ff) |-> $past(wd_expired_in))
		else $error("expired flag set without event");

	// Self-test results
	a_test_sec: assert property (
		##1 test_ff[5] == $past(single_error_corrected_in))
		else $error("correction bit wrong");
	a_test_fail: assert property (
		##1 test_ff[3:0] == $past(self_test_fail_in))
		else $error("self-test results wrong");

	// Cause record fields, loaded only with the event
	a_cause_ext: assert property (
		cause_event_in |=>
			last_ff[7] == $past(external_reset_input_in))
		else $error("external reset cause wrong");
	a_cause_wdr: assert property (
		cause_event_in |=>
			last_ff[6] == $past(watchdog_reset_cause_in))
		else $error("watchdog reset cause wrong");
	a_cause_emo: assert property (
		cause_event_in |=>
			last_ff[4] == $past(emergency_off_input_in))
		else $error("emergency off cause wrong");
	a_cause_run: assert property (
		cause_event_in |=>
			last_ff[3] == $past(run_low_cause_in))
		else $error("run low cause wrong");
	a_cause_wds: assert property (
		cause_event_in |=>
			last_ff[2] == $past(watchdog_shutdown_cause_in))
		else $error("watchdog shutdown cause wrong");
	a_forced_code: assert property (
		cause_event_in && !watchdog_shutdown_cause_in |=>
			last_ff[1:0] == $past(forced_off_code_in))
		else $error("forced off code not recorded");

	// Read-only behaviour of the port
	a_read_zero: assert property (
		rd_en_in && (addr_in < ssr_pkg::OFS_CTL_PIN ||
			addr_in > ssr_pkg::OFS_LAST) |=>
			rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_wdt_rsvd: assert property (
		wd_read |=> rdata_out[7:4] == 4'h0 && !rdata_out[2])
		else $error("watchdog reserved bit set");
	a_rdata_stable: assert property (
		!rd_en_in |=> $stable(rdata_out))
		else $error("read data changed without read");
	a_write_ignored: assert property (
		wr_en_in && !rd_en_in |=> $stable(rdata_out))
		else $error("write changed read data");
	a_write_no_clear: assert property (
		wr_en_in && wdata_in[1] && early_ff && !rd_en_in |=>
			early_ff)
		else $error("write cleared early flag");

	c_wd_read_set: cover property (wd_read && early_ff);
	c_cause_event: cover property (cause_event_in);
	c_state_active: cover property (ctl_ff[1:0] == 2'h3);
	c_ext_cause: cover property (last_ff[7]);
	c_set_wins: cover property (wd_read && wd_early_service_in);

endmodule : ssr_status_regs

//--- rtl/ssr_pkg.sv
// Package for the sequencer status register group.
// Assumes a byte-wide register port driven by an I2C slave outside.
package ssr_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CTL_PIN = 8'h13;
	localparam logic [7:0] OFS_DRV_HI = 8'h14;
	localparam logic [7:0] OFS_DRV_LO = 8'h15;
	localparam logic [7:0] OFS_RDB_HI = 8'h16;
	localparam logic [7:0] OFS_RDB_LO = 8'h17;
	localparam logic [7:0] OFS_WDT = 8'h18;
	localparam logic [7:0] OFS_TEST = 8'h19;
	localparam logic [7:0] OFS_LAST = 8'h1a;
	// Reset values
	localparam logic [7:0] RST_VAL = 8'h00;
	// Control status fields
	localparam int CTL_IRQ_BIT = 5;
	localparam int CTL_RST_BIT = 4;
	localparam int CTL_SLP_BIT = 3;
	localparam int CTL_RUN_BIT = 2;
	// Power state codes
	localparam logic [1:0] PS_OFF = 2'h0;
	localparam logic [1:0] PS_SLEEP = 2'h1;
	localparam logic [1:0] PS_ACTIVE = 2'h3;
	// Watchdog fields
	localparam int WD_OPEN_BIT = 3;
	localparam int WD_EARLY_BIT = 1;
	localparam int WD_EXP_BIT = 0;
	// Self-test fields
	localparam int ST_DONE_BIT = 6;
	localparam int ST_SEC_BIT = 5;
	// Last-reset-cause fields
	localparam int LR_EXT_BIT = 7;
	localparam int LR_WDR_BIT = 6;
	localparam int LR_EMO_BIT = 4;
	localparam int LR_RUN_BIT = 3;
	localparam int LR_WDS_BIT = 2;
	localparam int NUM_EN = 12;
	localparam int NUM_EN_HI = 4;
	localparam int SYNC_LEN = 3;
endpackage : ssr_pkg

//--- dv/ssr_host_model.sv
// Host model: reads and writes status bytes over the register port.
// Assumes a request is taken on the rising edge of clk_in.
`timescale 1ns/1ps
module ssr_host_model (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic rd_en_out,
	output logic wr_en_out,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in
);
	initial begin
		rd_en_out = 1'b0;
		wr_en_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	////////////////////////////////////////////////////////////////////
	// One strobe cycle, answer sampled a cycle later
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_in);
		rd_en_out = ~wr;
		wr_en_out = wr;
		addr_out = a;
		wdata_out = d;
		@(negedge clk_in);
		rd_en_out = 1'b0;
		wr_en_out = 1'b0;
		// Idle lines carry junk so a stale address is never reused
		addr_out = ~a;
		wdata_out = ~d;
		q = rdata_in;
	endtask : access
endmodule : ssr_host_model

//--- dv/ssr_status_regs_tb_top.sv
// Self-checking bench for the status register group.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module ssr_status_regs_tb_top;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic irq_lo, rst_lo, slp, run, wopen, wearly, wexp, done, sec, ev;
	logic ext, wdr, emo, rlow, wds, rd_en, wr_en;
	logic [7:0] addr, wdata, rdata, q;
	logic [11:0] drv, lvl;
	logic [1:0] ps, fcode, wmode;
	logic [3:0] fail;
	int n_fail = 0;
	int checks_done = 0;
	always #2 clk_in = ~clk_in;
	ssr_host_model i_ssr_host_model (.clk_in(clk_in), .rd_en_out(rd_en),
		.wr_en_out(wr_en), .addr_out(addr), .wdata_out(wdata),
		.rdata_in(rdata));
	ssr_status_regs i_ssr_status_regs (.clk_in(clk_in),
		.reset_in(reset_in), .rd_en_in(rd_en), .wr_en_in(wr_en),
		.addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
		.irq_drive_low_in(irq_lo), .rst_drive_low_in(rst_lo),
		.enable_drive_state_in(drv), .power_state_code_in(ps),
		.sleep_pin_in(slp), .run_request_input_in(run),
		.enable_pin_level_in(lvl), .wd_window_open_in(wopen),
		.wd_early_service_in(wearly), .wd_expired_in(wexp),
		.self_test_done_in(done), .single_error_corrected_in(sec),
		.self_test_fail_in(fail), .cause_event_in(ev),
		.external_reset_input_in(ext), .watchdog_reset_cause_in(wdr),
		.emergency_off_input_in(emo), .run_low_cause_in(rlow),
		.watchdog_shutdown_cause_in(wds), .forced_off_code_in(fcode),
		.watchdog_off_mode_in(wmode));
	////////////////////////////////////////////////////////////////////
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_ssr_host_model.access(1'b0, a, 8'h00, q);
		`CHK("rdata", e, q)
	endtask : rd
	task automatic wr(input logic [7:0] a);
		i_ssr_host_model.access(1'b1, a, 8'hff, q);
	endtask : wr
	task automatic t_reset();
		// Host reads cause record first, all bytes zero
		for (int a = 8'h1a; a >= 8'h12; a--) begin
			rd(8'(a), 8'h00);
		end
		rd(8'h1b, 8'h00);
	endtask : t_reset
	task automatic t_ctl();
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_in);
			{irq_lo, rst_lo, slp} = 3'(i);
			run = ~slp;
			ps = 2'(i >> 1);
			repeat (8) @(negedge clk_in);
			rd(8'h13, {2'h0, ~irq_lo, ~rst_lo, slp, run,
				(ps == 2'h2) ? 2'h0 : ps});
		end
	endtask : t_ctl
	task automatic t_en();
		@(negedge clk_in);
		drv = 12'ha5c;
		lvl = 12'h3c9;
		repeat (8) @(negedge clk_in);
		rd(8'h14, 8'h0a);
		rd(8'h15, 8'h5c);
		rd(8'h16, 8'h03);
		rd(8'h17, 8'hc9);
	endtask : t_en
	task automatic t_wdt();
		@(negedge clk_in);
		{wopen, wearly, wexp} = 3'h7;
		@(negedge clk_in);
		{wearly, wexp} = 2'h0;
		rd(8'h18, 8'h0b);
		rd(8'h18, 8'h08);
		// Early event lands in the very cycle of a read: set wins
		fork
			rd(8'h18, 8'h08);
			begin
				@(negedge clk_in);
				wearly = 1'b1;
				@(negedge clk_in);
				wearly = 1'b0;
			end
		join
		wr(8'h18);
		wr(8'h13);
		rd(8'h18, 8'h0a);
		wopen = 1'b0;
		rd(8'h18, 8'h00);
	endtask : t_wdt
	task automatic t_test();
		@(negedge clk_in);
		{done, sec, fail} = 6'h3a;
		repeat (2) @(negedge clk_in);
		rd(8'h19, 8'h6a);
		{done, sec, fail} = 6'h05;
		repeat (2) @(negedge clk_in);
		rd(8'h19, 8'h05);
	endtask : t_test
	// Cause inputs turn to junk after the pulse; the record must hold
	task automatic cause(input logic [7:0] v, input logic [1:0] m,
		input logic [7:0] e);
		@(negedge clk_in);
		{ext, wdr, emo, rlow, wds, fcode} = {v[7:6], v[4:0]};
		wmode = m;
		ev = 1'b1;
		@(negedge clk_in);
		ev = 1'b0;
		{ext, wdr, emo, rlow, wds, fcode} = ~{v[7:6], v[4:0]};
		wmode = ~m;
		rd(8'h1a, e);
		rd(8'h1a, e);
	endtask : cause
	task automatic t_cause();
		cause(8'h80, 2'h2, 8'h80);
		cause(8'h40, 2'h1, 8'h40);
		cause(8'h10, 2'h3, 8'h10);
		cause(8'h0a, 2'h1, 8'h0a);
		cause(8'h06, 2'h1, 8'h05);
		cause(8'h03, 2'h0, 8'h03);
		wr(8'h1a);
		rd(8'h1a, 8'h03);
	endtask : t_cause
	task automatic print_verdict();
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////
	initial begin
		{irq_lo, rst_lo, slp, run, wopen, wearly, wexp} = 7'h60;
		{done, sec, ev, ext, wdr, emo, rlow, wds} = 8'h00;
		{drv, lvl, ps, fcode, wmode, fail} = 34'h0;
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		reset_in = 1'b0;
		repeat (8) @(negedge clk_in);
		t_reset();
		t_ctl();
		t_en();
		t_wdt();
		t_test();
		t_cause();
		print_verdict();
	end
	// Whole run needs about 210 cycles
	initial begin
		#20000;
		n_fail++;
		print_verdict();
	end
endmodule : ssr_status_regs_tb_top
